// [verilog/pse_pin_pkg.sv]
/*
 * Shared constants and types for the quad power-source pin control block:
 * register offsets, field positions, reset values, timing counts, the
 * serial-slave state encoding and the reset-pushbutton message carrier.
 * Assumes a 50 MHz core clock.
 */
package pse_pin_pkg;
	localparam int  NPORT         = 4;
	localparam real CLK_PERIOD_NS = 20.0;

	// glitch filter: a least time, so rounded up
	localparam real GLITCH_US  = 1.0;
	localparam int  GLITCH_CYC = int'($ceil(GLITCH_US * 1000.0 / CLK_PERIOD_NS));

	// fault timer: a longest time, so rounded down
	localparam real FAULT_MS  = 62.5;
	localparam int  FAULT_CYC = int'($floor(FAULT_MS * 1.0e6 / CLK_PERIOD_NS));

	// register offsets
	localparam logic [7:0] REG_EVENT       = 8'h00;
	localparam logic [7:0] REG_INT_MASK    = 8'h01;
	localparam logic [7:0] REG_PIN_STATUS  = 8'h11;
	localparam logic [7:0] REG_MISC_CONFIG = 8'h17;
	localparam logic [7:0] REG_RESET_PUSHBUTTON    = 8'h1A;

	// field positions
	localparam int PB_CLR_LO      = 6;
	localparam int PB_CLR_HI      = 7;
	localparam int PIN_STRAP_BIT  = 0;
	localparam int PIN_MID_BIT    = 1;
	localparam int EV_STARTUP_LSB = 4;

	// upper bits of the serial slave address
	localparam logic [2:0] ADDR_HI = 3'h2;

	// reset values; the mask's pair picked by the standalone strap
	localparam logic [7:0] MASK_INIT_STANDALONE = 8'h00;
	localparam logic [7:0] MASK_INIT_HOST       = 8'hFF;
	localparam logic [7:0] MISC_INIT            = 8'h00;

	typedef enum logic [2:0] {
		ST_IDLE = 3'h0,
		ST_ADDR = 3'h1,
		ST_REG  = 3'h2,
		ST_WR   = 3'h3,
		ST_RD   = 3'h4,
		ST_ACK  = 3'h5,
		ST_RACK = 3'h6
	} i2c_state_t;

	// reset-pushbutton write passed from link domain to core domain
	typedef struct packed {
		logic [7:0] data;
		logic       tgl;
	} pb_msg_t;
endpackage : pse_pin_pkg

// [verilog/glitch_filter.sv]
/*
 * Two-flop synchroniser plus per-bit stability filter: an output bit
 * follows its input only after the input has held a new level for CYC
 * clocks. Assumes asynchronous pin inputs that idle high.
 */
`timescale 1ns/1ns
`default_nettype none
module glitch_filter #(
	parameter int WIDTH = 1,
	parameter int CYC   = pse_pin_pkg::GLITCH_CYC
)(
	input  wire logic             clk,
	input  wire logic             reset,
	input  wire logic [WIDTH-1:0] din,
	output logic      [WIDTH-1:0] dout
);
	localparam int CW = $clog2(CYC + 1);

	logic [WIDTH-1:0] meta_r;
	logic [WIDTH-1:0] sync_r;
	logic [WIDTH-1:0] out_r;
	logic [WIDTH-1:0] out_nxt;

	// synchroniser; first flop feeds only the second
	always_ff @(posedge clk) begin
		meta_r <= din;
		sync_r <= meta_r;
	end

	genvar i;
	generate
		for (i = 0; i < WIDTH; i++) begin : g_bit
			logic [CW-1:0] cnt_r;
			logic [CW-1:0] cnt_nxt;

			// count cycles the input disagrees; a short pulse restarts it
			always_comb begin
				out_nxt[i] = out_r[i];
				cnt_nxt    = '0;
				if (sync_r[i] != out_r[i]) begin
					if (cnt_r == CW'(CYC - 1)) begin
						out_nxt[i] = sync_r[i];
					end else begin
						cnt_nxt = CW'(cnt_r + 1'b1);
					end
				end
			end

			always_ff @(posedge clk) begin
				if (reset) begin
					cnt_r    <= '0;
					out_r[i] <= 1'b1;
				end else begin
					cnt_r    <= cnt_nxt;
					out_r[i] <= out_nxt[i];
				end
			end

			property p_filt;
				@(posedge clk) disable iff (reset)
				$changed(out_r[i]) |->
					($past(sync_r[i], 1) == out_r[i]) && ($past(sync_r[i], 8) == out_r[i]);
			endproperty
			a_filt: assert property (p_filt)
				else $error("filter output moved on a short pulse");
		end
	endgenerate

	assign dout = out_r;
endmodule : glitch_filter
`default_nettype wire

// [verilog/quad_pse_pin_control.sv]
/*
 * Pin control of a quad power-source controller: chip reset, port and
 * maskable shutdown, straps, per-port fault timer and switch drive,
 * power-good, interrupt pin, and a serial slave on split data pins.
 * Assumes comparator outputs for the analog sense points and a link clock
 * (at least 8x the serial clock) that oversamples the serial pins.
 */
`timescale 1ns/1ns
`default_nettype none
module quad_pse_pin_control #(
	parameter int FAULT_CYC  = pse_pin_pkg::FAULT_CYC,
	parameter int GLITCH_CYC = pse_pin_pkg::GLITCH_CYC
)(
	input  wire logic       clk,
	input  wire logic       reset,
	input  wire logic       link_clk,
	input  wire logic       chip_reset_n,
	input  wire logic [3:0] port_shutdown_n,
	input  wire logic       masked_shutdown_n,
	input  wire logic       standalone_strap,
	input  wire logic       midspan_sel,
	input  wire logic       addr_strap_3,
	input  wire logic       addr_strap_2,
	input  wire logic       addr_strap_1,
	input  wire logic       addr_strap_0,
	input  wire logic       scl_pin,
	input  wire logic       serial_data_in_pin,
	output logic            serial_data_out_pin_o,
	output logic            serial_data_out_pin_oe,
	output logic            int_pin_o,
	output logic            int_pin_oe,
	input  wire logic [3:0] port_on_req,
	input  wire logic [3:0] sense_over_threshold,
	input  wire logic [3:0] sense_at_limit,
	input  wire logic [3:0] port_voltage_low,
	output logic      [3:0] switch_drive,
	output logic      [3:0] gate_regulate,
	output logic      [3:0] power_good,
	output logic            midspan_mode
);
	localparam int CW = $clog2(FAULT_CYC + 1);

	// ---------------- core domain inputs ----------------
	logic [5:0]  filt;
	logic        core_rst_r;
	logic [13:0] pin_m_r;
	logic [13:0] pin_s_r;
	logic [3:0]  over_s;
	logic [3:0]  lim_s;
	logic [3:0]  pvl_s;
	logic        mid_s;

	// shutdown and chip reset pins share one filter
	glitch_filter #(
		.WIDTH (6),
		.CYC   (GLITCH_CYC)
	) u_filt (
		.clk   (clk),
		.reset (reset),
		.din   ({masked_shutdown_n, port_shutdown_n, chip_reset_n}),
		.dout  (filt)
	);

	// analog comparator and strap levels; first flop read only by second
	always_ff @(posedge clk) begin
		pin_m_r <= {port_voltage_low, sense_at_limit, sense_over_threshold,
			midspan_sel, standalone_strap};
		pin_s_r <= pin_m_r;
		core_rst_r <= reset | ~filt[0];
	end
	assign mid_s  = pin_s_r[1];
	assign over_s = pin_s_r[5:2];
	assign lim_s  = pin_s_r[9:6];
	assign pvl_s  = pin_s_r[13:10];

	// ---------------- link domain: serial slave ----------------
	pse_pin_pkg::i2c_state_t st_r, st_nxt, after_r, after_nxt;
	pse_pin_pkg::pb_msg_t    pb_r, pb_nxt;
	logic       lrst_m_r;
	logic       lrst_r;
	logic [7:0] lpin_m_r;
	logic [7:0] lpin_s_r;
	logic       scl_d_r;
	logic       sda_d_r;
	logic [7:0] ev_m_r;
	logic [7:0] ev_s_r;
	logic [2:0] bitc_r, bitc_nxt;
	logic [7:0] sh_r, sh_nxt;
	logic [7:0] ptr_r, ptr_nxt;
	logic [7:0] mask_r, mask_nxt;
	logic [7:0] misc_r, misc_nxt;
	logic       ackph_r, ackph_nxt;
	logic       drv_r, drv_nxt;
	logic       busy_r;
	logic       scl_s, sda_s, rise, fall, start, stop;
	logic [6:0] my_addr;
	logic [7:0] byte_in;
	logic [7:0] rdata;
	logic [7:0] events_r;

	// reset, straps, serial pins and event status into link domain
	always_ff @(posedge link_clk) begin
		lrst_m_r <= core_rst_r;
		lrst_r   <= lrst_m_r;
		lpin_m_r <= {addr_strap_3, addr_strap_2, addr_strap_1, addr_strap_0,
			midspan_sel, standalone_strap, serial_data_in_pin, scl_pin};
		lpin_s_r <= lpin_m_r;
		scl_d_r  <= lpin_s_r[0];
		sda_d_r  <= lpin_s_r[1];
		ev_m_r   <= events_r; // sticky bits change slowly, read as a level
		ev_s_r   <= ev_m_r;
	end

	assign scl_s   = lpin_s_r[0];
	assign sda_s   = lpin_s_r[1]; // data read from the input pin only
	assign rise    = scl_s & ~scl_d_r;
	assign fall    = ~scl_s & scl_d_r;
	assign start   = scl_s & scl_d_r & sda_d_r & ~sda_s;
	assign stop    = scl_s & scl_d_r & ~sda_d_r & sda_s;
	assign my_addr = {pse_pin_pkg::ADDR_HI, lpin_s_r[7:4]};
	assign byte_in = {sh_r[6:0], sda_s};

	// register read mux; reset pushbutton is write-only
	always_comb begin
		rdata = 8'h00;
		case (ptr_r)
			pse_pin_pkg::REG_EVENT:       rdata = ev_s_r;
			pse_pin_pkg::REG_INT_MASK:    rdata = mask_r;
			pse_pin_pkg::REG_MISC_CONFIG: rdata = misc_r;
			pse_pin_pkg::REG_PIN_STATUS: begin
				rdata[pse_pin_pkg::PIN_STRAP_BIT] = lpin_s_r[2];
				rdata[pse_pin_pkg::PIN_MID_BIT]   = lpin_s_r[3];
			end
			default: rdata = 8'h00;
		endcase
	end

	// slave sequencer: sample on scl rise, drive on scl fall
	always_comb begin
		st_nxt    = st_r;
		after_nxt = after_r;
		bitc_nxt  = bitc_r;
		sh_nxt    = sh_r;
		ptr_nxt   = ptr_r;
		mask_nxt  = mask_r;
		misc_nxt  = misc_r;
		pb_nxt    = pb_r;
		ackph_nxt = ackph_r;
		drv_nxt   = drv_r;
		if (lrst_r) begin
			st_nxt    = pse_pin_pkg::ST_IDLE;
			after_nxt = pse_pin_pkg::ST_IDLE;
			bitc_nxt  = 3'h0;
			sh_nxt    = 8'h00;
			ptr_nxt   = 8'h00;
			mask_nxt  = lpin_s_r[2] ? pse_pin_pkg::MASK_INIT_STANDALONE
				: pse_pin_pkg::MASK_INIT_HOST;
			misc_nxt  = pse_pin_pkg::MISC_INIT;
			pb_nxt    = '0;
			ackph_nxt = 1'b0;
			drv_nxt   = 1'b0;
		end else if (start) begin
			st_nxt    = pse_pin_pkg::ST_ADDR;
			bitc_nxt  = 3'h0;
			ackph_nxt = 1'b0;
			drv_nxt   = 1'b0;
		end else if (stop) begin
			st_nxt  = pse_pin_pkg::ST_IDLE;
			drv_nxt = 1'b0;
		end else begin
			unique case (st_r)
				pse_pin_pkg::ST_IDLE: begin
				end
				pse_pin_pkg::ST_ADDR, pse_pin_pkg::ST_REG, pse_pin_pkg::ST_WR: begin
					if (rise) begin
						sh_nxt   = byte_in;
						bitc_nxt = 3'(bitc_r + 3'h1);
						if (bitc_r == 3'h7) begin
							st_nxt    = pse_pin_pkg::ST_ACK;
							after_nxt = pse_pin_pkg::ST_WR;
							if (st_r == pse_pin_pkg::ST_ADDR) begin
								if (byte_in[7:1] != my_addr) begin
									st_nxt = pse_pin_pkg::ST_IDLE;
								end else if (byte_in[0]) begin
									after_nxt = pse_pin_pkg::ST_RD;
								end else begin
									after_nxt = pse_pin_pkg::ST_REG;
								end
							end else if (st_r == pse_pin_pkg::ST_REG) begin
								ptr_nxt = byte_in;
							end else if (ptr_r == pse_pin_pkg::REG_INT_MASK) begin
								mask_nxt = byte_in;
							end else if (ptr_r == pse_pin_pkg::REG_MISC_CONFIG) begin
								misc_nxt = byte_in;
							end else if (ptr_r == pse_pin_pkg::REG_RESET_PUSHBUTTON) begin
								pb_nxt = {byte_in, ~pb_r.tgl};
							end
						end
					end
				end
				pse_pin_pkg::ST_ACK: begin
					if (fall) begin
						if (!ackph_r) begin
							ackph_nxt = 1'b1;
							drv_nxt   = 1'b1;
						end else begin
							ackph_nxt = 1'b0;
							bitc_nxt  = 3'h0;
							st_nxt    = after_r;
							drv_nxt   = 1'b0;
							if (after_r == pse_pin_pkg::ST_RD) begin
								sh_nxt  = rdata;
								drv_nxt = ~rdata[7];
							end
						end
					end
				end
				pse_pin_pkg::ST_RD: begin
					if (rise) begin
						bitc_nxt = 3'(bitc_r + 3'h1);
						if (bitc_r == 3'h7) begin
							st_nxt = pse_pin_pkg::ST_RACK;
						end
					end else if (fall) begin
						sh_nxt  = {sh_r[6:0], 1'b0};
						drv_nxt = ~sh_r[6];
					end
				end
				pse_pin_pkg::ST_RACK: begin
					if (fall) begin
						drv_nxt = 1'b0;
					end else if (rise) begin
						// master ack: reload next fall; nack: wait for stop
						st_nxt    = sda_s ? pse_pin_pkg::ST_IDLE : pse_pin_pkg::ST_ACK;
						ackph_nxt = 1'b1;
						after_nxt = pse_pin_pkg::ST_RD;
					end
				end
				default: st_nxt = pse_pin_pkg::ST_IDLE;
			endcase
		end
	end

	always_ff @(posedge link_clk) begin
		st_r    <= st_nxt;
		after_r <= after_nxt;
		bitc_r  <= bitc_nxt;
		sh_r    <= sh_nxt;
		ptr_r   <= ptr_nxt;
		mask_r  <= mask_nxt;
		misc_r  <= misc_nxt;
		pb_r    <= pb_nxt;
		ackph_r <= ackph_nxt;
		drv_r   <= drv_nxt;
		busy_r  <= (st_nxt != pse_pin_pkg::ST_IDLE);
	end

	assign serial_data_out_pin_o  = 1'b0;
	assign serial_data_out_pin_oe = drv_r; // open drain

	// ---------------- link to core crossing ----------------
	// config levels and busy by two flops; pushbutton data held stable
	// until the next write, so only its toggle needs synchronising
	logic [16:0] cfg_m_r;
	logic [16:0] cfg_s_r;
	logic        pb_d_r;
	logic        pb_pulse;
	logic [7:0]  mask_s;
	logic [3:0]  misc_s;
	logic        busy_s;

	always_ff @(posedge clk) begin
		cfg_m_r <= {pb_r.tgl, busy_r, misc_r[3:0], mask_r, 3'h0};
		cfg_s_r <= cfg_m_r;
		pb_d_r  <= cfg_s_r[16];
	end
	assign busy_s   = cfg_s_r[15];
	assign misc_s   = cfg_s_r[14:11];
	assign mask_s   = cfg_s_r[10:3];
	assign pb_pulse = (cfg_s_r[16] ^ pb_d_r) & ~core_rst_r;

	// ---------------- core: ports, events, interrupt ----------------
	logic [CW-1:0] cnt_r [4];
	logic [CW-1:0] cnt_nxt [4];
	logic [3:0] trip_r, trip_nxt;
	logic [3:0] drive_r, drive_nxt;
	logic [3:0] exp;
	logic [3:0] kill;
	logic [3:0] starting;
	logic [7:0] ev_set;
	logic [7:0] events_nxt;
	logic       pb_clear;
	logic       int_low_r, int_low_nxt;
	logic [3:0] gate_r;
	logic [3:0] pg_r;
	logic       mid_r;

	genvar p;
	generate
		for (p = 0; p < 4; p++) begin : g_port
			// port reset sources, then fault timer and its expiry
			always_comb begin
				kill[p] = ~filt[p + 1]
					| (~filt[5] & misc_s[p])
					| (pb_pulse & pb_r.data[p]);
				exp[p]  = 1'b0;
				cnt_nxt[p] = cnt_r[p];
				if (!drive_r[p]) begin
					cnt_nxt[p] = '0;
				end else if (over_s[p]) begin
					if (cnt_r[p] == CW'(FAULT_CYC - 1)) begin
						exp[p]     = 1'b1;
						cnt_nxt[p] = '0;
					end else begin
						cnt_nxt[p] = CW'(cnt_r[p] + 1'b1);
					end
				end else if (cnt_r[p] != '0) begin
					cnt_nxt[p] = CW'(cnt_r[p] - 1'b1); // bleeds off between bursts
				end
				if (core_rst_r) begin
					cnt_nxt[p] = '0;
				end
			end
			always_ff @(posedge clk) begin
				cnt_r[p] <= cnt_nxt[p];
			end
		end
	endgenerate

	assign starting = drive_r & ~pvl_s;
	assign ev_set   = {exp & starting, exp & ~starting};
	assign pb_clear = pb_pulse & (pb_r.data[pse_pin_pkg::PB_CLR_LO]
		| pb_r.data[pse_pin_pkg::PB_CLR_HI]);

	// tripped ports stay off until the request drops; set wins over clear
	always_comb begin
		trip_nxt    = (trip_r & port_on_req) | kill | exp;
		drive_nxt   = port_on_req & ~trip_nxt;
		events_nxt  = (pb_clear ? 8'h00 : events_r) | ev_set;
		int_low_nxt = busy_s ? int_low_r
			: ((events_r & mask_s) != 8'h00);
		if (core_rst_r) begin
			trip_nxt    = 4'h0;
			drive_nxt   = 4'h0;
			events_nxt  = 8'h00;
			int_low_nxt = 1'b0;
		end
	end

	always_ff @(posedge clk) begin
		trip_r    <= trip_nxt;
		drive_r   <= drive_nxt;
		events_r  <= events_nxt;
		int_low_r <= int_low_nxt;
		gate_r    <= drive_nxt & lim_s;
		pg_r      <= core_rst_r ? 4'h0 : pvl_s;
		mid_r     <= core_rst_r ? 1'b0 : mid_s;
	end

	assign switch_drive  = drive_r;
	assign gate_regulate = gate_r;
	assign power_good    = pg_r;
	assign midspan_mode  = mid_r;
	assign int_pin_o     = 1'b0;
	assign int_pin_oe    = int_low_r;

	// ---------------- checks ----------------
	property p_reset_off;
		@(posedge clk) core_rst_r |=> (switch_drive == 4'h0) && !int_pin_oe;
	endproperty
	a_reset_off: assert property (p_reset_off)
		else $error("port or interrupt active in reset");

	property p_int_clear;
		@(posedge clk) disable iff (core_rst_r)
		(pb_clear && (ev_set == 8'h00)) |=> (events_r == 8'h00);
	endproperty
	a_int_clear: assert property (p_int_clear)
		else $error("events not cleared by pushbutton write");

	property p_int_raise;
		@(posedge clk) disable iff (core_rst_r)
		(!busy_s && ((events_r & mask_s) != 8'h00)) |=> int_pin_oe;
	endproperty
	a_int_raise: assert property (p_int_raise)
		else $error("unmasked event did not pull interrupt low");

	property p_int_mask;
		@(posedge clk) disable iff (core_rst_r)
		(!busy_s && ((events_r & mask_s) == 8'h00)) |=> !int_pin_oe;
	endproperty
	a_int_mask: assert property (p_int_mask)
		else $error("masked event pulled interrupt low");

	property p_int_hold;
		@(posedge clk) disable iff (core_rst_r) busy_s |=> $stable(int_pin_oe);
	endproperty
	a_int_hold: assert property (p_int_hold)
		else $error("interrupt changed during a transaction");

	property p_shdn;
		@(posedge clk) disable iff (core_rst_r)
		(filt[4:1] != 4'hF) |=> ((~$past(filt[4:1]) & switch_drive) == 4'h0);
	endproperty
	a_shdn: assert property (p_shdn)
		else $error("port on while its shutdown is low");

	property p_msd;
		@(posedge clk) disable iff (core_rst_r)
		!filt[5] |=> (($past(misc_s) & switch_drive) == 4'h0);
	endproperty
	a_msd: assert property (p_msd)
		else $error("selected port on during maskable shutdown");

	property p_fault_off;
		@(posedge clk) disable iff (core_rst_r)
		(exp != 4'h0) |=> ((switch_drive & $past(exp)) == 4'h0)
			&& ((events_r & {$past(exp), $past(exp)}) != 8'h00);
	endproperty
	a_fault_off: assert property (p_fault_off)
		else $error("expired port not switched off or not logged");

	property p_fault_time;
		@(posedge clk) disable iff (core_rst_r)
		(drive_r[0] && over_s[0] && (cnt_r[0] == CW'(FAULT_CYC - 1))) |=> !switch_drive[0];
	endproperty
	a_fault_time: assert property (p_fault_time)
		else $error("port 0 survived full fault time");

	property p_addr_ack;
		@(posedge link_clk) disable iff (lrst_r)
		(st_r == pse_pin_pkg::ST_ADDR && rise && bitc_r == 3'h7 && byte_in[7:1] == my_addr)
			|=> (st_r == pse_pin_pkg::ST_ACK) ##1 (st_r == pse_pin_pkg::ST_ACK);
	endproperty
	a_addr_ack: assert property (p_addr_ack)
		else $error("own address not acknowledged");

	c_fault: cover property (@(posedge clk) exp != 4'h0);
	c_int:   cover property (@(posedge clk) $rose(int_low_r));
	c_pb:    cover property (@(posedge clk) pb_clear);
	c_read:  cover property (@(posedge link_clk) st_r == pse_pin_pkg::ST_RACK);
endmodule : quad_pse_pin_control
`default_nettype wire

// [dv/i2c_host.sv]
/*
 * Host-side serial master model: start, stop, byte transfer, register
 * write and read. Assumes the data line is resolved with a pull-up outside.
 */
`timescale 1ns/1ns
`default_nettype none
module i2c_host (
	input  wire logic link_clk,
	input  wire logic sda_line,
	output logic      scl,
	output logic      sda_drv
);
	logic [6:0] dev_addr;
	initial begin
		scl = 1'b1;
		sda_drv = 1'b1;
		dev_addr = 7'h2A;
	end
	// quarter serial period; keeps scl well under an eighth of link rate
	task q;
		repeat (4) @(posedge link_clk);
	endtask : q
	// also a repeated start when entered with scl low
	task start;
		sda_drv <= 1'b1;
		q();
		scl <= 1'b1;
		q();
		sda_drv <= 1'b0;
		q();
		scl <= 1'b0;
		q();
	endtask : start
	task stop;
		sda_drv <= 1'b0;
		q();
		scl <= 1'b1;
		q();
		sda_drv <= 1'b1;
		q();
		q();
	endtask : stop
	// data set while scl low, sampled mid-high
	task bit_x(input logic b, output logic r);
		sda_drv <= b;
		q();
		scl <= 1'b1;
		q();
		r = sda_line;
		q();
		scl <= 1'b0;
		q();
	endtask : bit_x
	// msb first, ninth bit released so the other side may pull it low
	task byte_x(input logic [7:0] d, output logic [7:0] r, output logic ack);
		logic a;
		for (int i = 7; i >= 0; i--) bit_x(d[i], r[i]);
		bit_x(1'b1, a);
		ack = ~a;
	endtask : byte_x
	task wr(input logic [7:0] a, input logic [7:0] d, output logic ok);
		logic [7:0] r;
		logic       k1, k2, k3;
		start();
		byte_x({dev_addr, 1'b0}, r, k1);
		byte_x(a, r, k2);
		byte_x(d, r, k3);
		stop();
		ok = k1 & k2 & k3;
	endtask : wr
	task rd(input logic [7:0] a, output logic [7:0] d, output logic ok);
		logic [7:0] r;
		logic       k1, k2, k3, k4;
		start();
		byte_x({dev_addr, 1'b0}, r, k1);
		byte_x(a, r, k2);
		start();
		byte_x({dev_addr, 1'b1}, r, k3);
		byte_x(8'hFF, d, k4);
		stop();
		ok = k1 & k2 & k3;
	endtask : rd
endmodule : i2c_host
`default_nettype wire

// [dv/tb_top.sv]
/*
 * Self-checking bench for the pin control block: serial register access,
 * fault timer, interrupt pin, shutdown pins and chip reset.
 * Assumes the serial master model in i2c_host.
 */
`timescale 1ns/1ns
`default_nettype none
module tb_top;
	logic       clk = 1'b0;
	logic       reset = 1'b1;
	logic       link_clk = 1'b0;
	logic       chip_reset_n = 1'b1;
	logic [3:0] shdn_n = 4'hF;
	logic       msd_n = 1'b1;
	logic       strap = 1'b0;
	logic       mid = 1'b0;
	logic [3:0] astrap = 4'hA;
	logic [3:0] on_req = 4'h0;
	logic [3:0] over = 4'h0;
	logic [3:0] lim = 4'h0;
	logic [3:0] vlow = 4'h0;
	wire logic  scl, sda_drv, sda_line, sd_o, sd_oe, int_o, int_oe, mid_mode;
	wire logic [3:0] sw, gate_reg, pg;
	int         err_count = 0;
	int         checked = 0;
	logic [7:0] rdat;
	logic       ok;
	always #10 clk = ~clk;
	initial begin
		#13;
		forever #40 link_clk = ~link_clk;
	end
	// open-drain data out wired to data in with a pull-up
	assign sda_line = sda_drv & ~(sd_oe & ~sd_o);
	i2c_host host (.link_clk(link_clk), .sda_line(sda_line), .scl(scl), .sda_drv(sda_drv));
	quad_pse_pin_control #(.FAULT_CYC(200), .GLITCH_CYC(10)) dut (
		.clk(clk), .reset(reset), .link_clk(link_clk), .chip_reset_n(chip_reset_n),
		.port_shutdown_n(shdn_n), .masked_shutdown_n(msd_n), .standalone_strap(strap),
		.midspan_sel(mid), .addr_strap_3(astrap[3]), .addr_strap_2(astrap[2]),
		.addr_strap_1(astrap[1]), .addr_strap_0(astrap[0]), .scl_pin(scl),
		.serial_data_in_pin(sda_line), .serial_data_out_pin_o(sd_o),
		.serial_data_out_pin_oe(sd_oe), .int_pin_o(int_o), .int_pin_oe(int_oe),
		.port_on_req(on_req), .sense_over_threshold(over), .sense_at_limit(lim),
		.port_voltage_low(vlow), .switch_drive(sw), .gate_regulate(gate_reg),
		.power_good(pg), .midspan_mode(mid_mode));
	task test_done;
		$display("checks %0d errors %0d", checked, err_count);
		if (err_count == 0 && checked > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask : test_done
	task chk(input logic [7:0] got, input logic [7:0] exp);
		checked++;
		if (got !== exp) begin
			err_count++;
			$display("wrong value at %0t: got %h want %h", $time, got, exp);
		end
	endtask : chk
	task cyc(input int n);
		repeat (n) @(posedge clk);
	endtask : cyc
	// sampled at the falling edge, then back on a rising edge for driving
	task see(input logic [7:0] got, input logic [7:0] exp);
		@(negedge clk);
		chk(got, exp);
		@(posedge clk);
	endtask : see
	task wait_sw(input logic [3:0] exp, input int n);
		@(negedge clk);
		for (int i = 0; i < n && sw !== exp; i++) @(negedge clk);
		chk({4'h0, sw}, {4'h0, exp});
		@(posedge clk);
	endtask : wait_sw
	task wr(input logic [7:0] a, input logic [7:0] d);
		host.wr(a, d, ok);
		chk({7'h0, ok}, 8'h01);
		cyc(5);
	endtask : wr
	task rd(input logic [7:0] a, input logic [7:0] exp);
		host.rd(a, rdat, ok);
		chk({7'h0, ok}, 8'h01);
		chk(rdat, exp);
		cyc(5);
	endtask : rd
	// watchdog well past the expected run length
	initial begin
		#1900000;
		err_count++;
		test_done();
	end
	initial begin
		cyc(20);
		reset <= 1'b0;
		cyc(20);
		rd(8'h01, 8'hFF);
		rd(8'h00, 8'h00);
		rd(8'h05, 8'h00);
		strap <= 1'b1;
		mid <= 1'b1;
		cyc(5);
		see({7'h0, mid_mode}, 8'h01);
		rd(8'h11, 8'h03);
		wr(8'h11, 8'h00);
		rd(8'h11, 8'h03);
		wr(8'h17, 8'h5A);
		rd(8'h17, 8'h5A);
		astrap <= 4'hB;
		cyc(5);
		host.wr(8'h17, 8'h00, ok);
		chk({7'h0, ok}, 8'h00);
		host.dev_addr = 7'h2B;
		rd(8'h17, 8'h5A);
		// startup fault on port 0, run fault on port 1, limit on port 2
		vlow <= 4'h2;
		on_req <= 4'hF;
		wait_sw(4'hF, 10);
		over <= 4'h3;
		lim <= 4'h4;
		cyc(150);
		see({4'h0, sw}, 8'h0F);
		see({4'h0, gate_reg}, 8'h04);
		see({4'h0, pg}, 8'h02);
		wait_sw(4'hC, 100);
		over <= 4'h0;
		lim <= 4'h0;
		cyc(5);
		see({7'h0, int_oe}, 8'h01);
		rd(8'h00, 8'h12);
		wr(8'h01, 8'h01);
		see({7'h0, int_oe}, 8'h00);
		wr(8'h01, 8'h10);
		for (int b = 6; b < 8; b++) begin
			on_req <= 4'hE;
			cyc(3);
			on_req <= 4'hF;
			over <= 4'h1;
			cyc(5);
			wait_sw(4'hC, 300);
			over <= 4'h0;
			cyc(5);
			see({7'h0, int_oe}, 8'h01);
			wr(8'h1A, 8'h01 << b);
			see({7'h0, int_oe}, 8'h00);
		end
		rd(8'h00, 8'h00);
		on_req <= 4'h0;
		cyc(3);
		on_req <= 4'hF;
		wait_sw(4'hF, 10);
		shdn_n <= 4'h7;
		cyc(5);
		shdn_n <= 4'hF;
		wait_sw(4'hF, 20);
		shdn_n <= 4'h7;
		wait_sw(4'h7, 30);
		shdn_n <= 4'hF;
		wr(8'h1A, 8'h04);
		wait_sw(4'h3, 10);
		wr(8'h17, 8'h02);
		msd_n <= 1'b0;
		cyc(5);
		msd_n <= 1'b1;
		wait_sw(4'h3, 20);
		msd_n <= 1'b0;
		wait_sw(4'h1, 30);
		msd_n <= 1'b1;
		wr(8'h01, 8'hFF);
		chip_reset_n <= 1'b0;
		cyc(5);
		chip_reset_n <= 1'b1;
		wait_sw(4'h1, 20);
		chip_reset_n <= 1'b0;
		wait_sw(4'h0, 70);
		chip_reset_n <= 1'b1;
		cyc(30);
		rd(8'h01, 8'h00);
		rd(8'h17, 8'h00);
		test_done();
	end
endmodule : tb_top
`default_nettype wire
